/* dv/boot_chk_asserts.sv */
// Purpose: Port-level checks of the error reply and the halt.
// Assumes: Events arrive only while the block is idle.
// Notes:   Bound to every boot_chk instance below.
`timescale 1ns/1ns
`default_nettype none
module boot_chk_asserts
   import boot_chk_pkg::*;
(
   // Clock, reset and error events
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       ev_baud_err,
   input  wire logic       ev_cmd_err,
   input  wire logic       ev_frame_err,
   input  wire logic       ev_overrun_err,
   // Transmitter and halt
   input  wire logic       tx_ready,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       halted
);
   // ==========================================================
   // Error reply: code two cycles after the event, held for three.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic idle;
   assign idle = !tx_valid && !halted;
   sequence three_sent;
      (tx_valid && tx_ready)[*3];
   endsequence
   a_frame_code: assert property (ev_frame_err && idle
      |-> ##2 tx_valid && tx_data == ERR_FRAME) else $error("frame code");
   a_overrun_code: assert property (ev_overrun_err && !ev_frame_err
      && idle |-> ##2 tx_valid && tx_data == ERR_OVERRUN)
      else $error("overrun code");
   a_baud_code: assert property (ev_baud_err && !ev_overrun_err
      && !ev_frame_err && idle |-> ##2 tx_valid && tx_data == ERR_BAUD)
      else $error("baud code");
   a_cmd_code: assert property (ev_cmd_err && !ev_baud_err
      && !ev_overrun_err && !ev_frame_err && idle
      |-> ##2 tx_valid && tx_data == ERR_CMD) else $error("command code");
   a_code_steady: assert property ($rose(tx_valid)
      |=> $stable(tx_data)[*2]) else $error("code changed");
   a_halt_after: assert property ($rose(tx_valid) ##0 three_sent
      |-> ##2 halted) else $error("no halt after code");
   a_halt_sticky: assert property (halted |=> halted)
      else $error("halt left");
   a_halt_silent: assert property (halted |-> !tx_valid)
      else $error("sent while halted");
endmodule
bind boot_chk boot_chk_asserts chk (.ref_clk, .rstn, .ev_baud_err,
   .ev_cmd_err, .ev_frame_err, .ev_overrun_err, .tx_ready, .tx_valid,
   .tx_data, .halted);
`default_nettype wire

/* dv/flash_model.sv */
// Purpose: Flash read partner for boot_chk.
// Assumes: One read in flight at a time.
// Notes:   Answers DLY cycles after the read strobe.
`timescale 1ns/1ns
`default_nettype none
module flash_model #(parameter int DLY = 2) (
   // Clock and read port
   input  wire logic        ref_clk,
   input  wire logic        fl_rd,
   input  wire logic [15:0] fl_addr,
   input  wire logic        blank_img,
   output logic             fl_ack,
   output logic [7:0]       fl_data
);
   // ==========================================================
   // Count 08h at f000h, password 01h..08h after it, top page all blank_img.
   logic [15:0] a;
   int          cnt = 0;
   initial fl_data = 8'h5a;
   // Idle data wanders so that a stale byte never passes for an answer.
   always @(posedge ref_clk) begin
      fl_ack <= 1'b0;
      fl_data <= ~fl_data;
      if (fl_rd) begin
         a <= fl_addr;
         cnt <= DLY;
      end else if (cnt == 1) begin
         fl_ack <= 1'b1;
         cnt <= 0;
         fl_data <= (a >= 16'hffe0) ? {8{blank_img}} :
            (a == 16'hf000) ? 8'h08 : (a[15:8] == 8'hf0) ? a[7:0] : 8'hff;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule
`default_nettype wire

/* dv/tb.sv */
// Purpose: Self-checking bench for boot_chk.
// Assumes: Inputs move on the falling edge; tx_ready stays high.
// Notes:   Each run starts from reset, since a halt is sticky.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
$display("Error %s expected %h seen %h", n, e, s); end end
module tb;
   // ==========================================================
   // Signals, design and flash partner.
   logic ref_clk, rstn, ev_baud_err, ev_cmd_err, ev_frame_err, ev_overrun_err;
   logic rx_valid, rx_err, dl_start, pwd_start, sum_start, xfer_valid;
   logic erase_mode, fl_rd, fl_ack, tx_ready, tx_valid, sum_done, dl_ok;
   logic pwd_ok, blank, halted, blank_img;
   logic [7:0] rx_data, xfer_index, xfer_byte, fl_data, tx_data;
   logic [2:0] sum_mode;
   logic [15:0] sum_lo, sum_hi, fl_addr, checksum;
   logic [3:0] seen;
   int failures = 0;
   int checked = 0;
   typedef logic [7:0] bytes_t [$];
   boot_chk dut (.ref_clk, .rstn, .ev_baud_err, .ev_cmd_err, .ev_frame_err,
      .ev_overrun_err, .rx_valid, .rx_data, .rx_err, .dl_start, .pwd_start,
      .sum_start, .sum_mode, .sum_lo, .sum_hi, .xfer_index, .xfer_byte,
      .xfer_valid, .erase_mode, .fl_addr, .fl_rd, .fl_data, .fl_ack,
      .tx_ready, .tx_valid, .tx_data, .checksum, .sum_done, .dl_ok,
      .pwd_ok, .blank, .halted);
   flash_model #(.DLY(2)) flash (.ref_clk, .fl_rd, .fl_addr, .blank_img,
      .fl_ack, .fl_data);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Short pulses are caught here so a task never misses one.
   always @(posedge ref_clk) seen <= seen | {sum_done, pwd_ok, dl_ok,
      tx_valid};
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic do_reset;
      seen = 4'h0;
      rstn = 1'b0;
      tick(3);
      rstn = 1'b1;
   endtask
   task automatic send(input logic [7:0] b);
      rx_data = b;
      rx_valid = 1'b1;
      tick(1);
      rx_valid = 1'b0;
      tick(9);
   endtask
   task automatic err_case(input int k, input logic [7:0] code);
      do_reset;
      {ev_baud_err, ev_cmd_err, ev_frame_err, ev_overrun_err} = 4'h8 >> k;
      tick(1);
      {ev_baud_err, ev_cmd_err, ev_frame_err, ev_overrun_err} = 4'h0;
      for (int i = 0; i < 3; i++) begin
         for (int t = 0; t < 9 && tx_valid !== 1'b1; t++) tick(1);
         `CHK("error code", code, tx_data)
         tick(1);
      end
      tick(3);
      `CHK("halt after code", 1'b1, halted)
   endtask
   task automatic dl_run(input bytes_t q, input logic ok);
      do_reset;
      dl_start = 1'b1;
      tick(1);
      dl_start = 1'b0;
      foreach (q[i]) send(q[i]);
      tick(20);
      `CHK("download result", {ok, 1'b0}, seen[1:0])
      `CHK("download halt", !ok, halted)
   endtask
   task automatic pwd_run(input logic bl, input bytes_t q, input logic ok);
      do_reset;
      blank_img = bl;
      pwd_start = 1'b1;
      tick(1);
      pwd_start = 1'b0;
      tick(250);
      foreach (q[i]) send(q[i]);
      tick(40);
      `CHK("blank flag", bl, blank)
      `CHK("password result", {ok, 1'b0}, {seen[2], seen[0]})
      `CHK("password halt", !ok, halted)
   endtask
   task automatic sum_run(input logic [2:0] m, input logic [15:0] exp_sum);
      do_reset;
      sum_mode = m;
      sum_start = 1'b1;
      tick(1);
      sum_start = 1'b0;
      for (int i = 1; i <= 18; i++) begin
         {xfer_valid, xfer_index, xfer_byte} = {1'b1, 8'(i), 8'(8'hf0 + i)};
         tick(1);
      end
      xfer_valid = 1'b0;
      tick(5);
      `CHK("sum done", 1'b1, seen[3])
      `CHK("checksum", exp_sum, checksum)
   endtask
   task automatic close_out;
      $display("Checks %0d, errors %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Hang guard, far beyond the few thousand cycles the runs need.
   initial begin
      #500000;
      failures++;
      close_out;
   end
   // Main sequence.
   initial begin
      {ev_baud_err, ev_cmd_err, ev_frame_err, ev_overrun_err} = 4'h0;
      {rx_valid, rx_err, dl_start, pwd_start, sum_start, xfer_valid} = 6'h0;
      {rx_data, xfer_index, xfer_byte, sum_mode, erase_mode} = 28'h0;
      {sum_lo, sum_hi, tx_ready, blank_img, rstn} = 35'h78007801c;
      err_case(0, 8'h62);
      err_case(1, 8'h63);
      err_case(2, 8'ha1);
      err_case(3, 8'ha3);
      dl_run('{8'h3a, 8'h01, 8'hc0, 8'h00, 8'h00, 8'h55, 8'hea, 8'h11,
         8'h3a, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff}, 1'b1);
      dl_run('{8'h3a, 8'h00, 8'h00, 8'h00, 8'h03, 8'hfd}, 1'b0);
      dl_run('{8'h3a, 8'h01, 8'hc0, 8'h00, 8'h00, 8'h55, 8'heb}, 1'b0);
      dl_run('{8'h3a, 8'h01, 8'h00, 8'h00, 8'h02, 8'h10, 8'hed}, 1'b0);
      dl_run('{8'h3a, 8'h02, 8'h00, 8'h00, 8'h02, 8'h10, 8'h00, 8'hec,
         8'h3a, 8'h01, 8'h00, 8'h00, 8'h00, 8'h55, 8'haa}, 1'b0);
      pwd_run(1'b1, '{8'hf0, 8'h00, 8'hf0, 8'h01}, 1'b1);
      pwd_run(1'b0, '{8'hf0, 8'h00, 8'hf0, 8'h01, 8'h01, 8'h02, 8'h03,
         8'h04, 8'h05, 8'h06, 8'h07, 8'h08}, 1'b1);
      pwd_run(1'b0, '{8'hf0, 8'h00, 8'hf0, 8'h01, 8'h01, 8'h02, 8'h03,
         8'h04, 8'h05, 8'h06, 8'h07, 8'h09}, 1'b0);
      pwd_run(1'b0, '{8'hf0, 8'h00, 8'hff, 8'h99}, 1'b0);
      rx_err = 1'b1;
      pwd_run(1'b1, '{8'hf0}, 1'b0);
      sum_run(3'h2, 16'h06e7);
      sum_run(3'h3, 16'h03ea);
      sum_run(3'h4, 16'h000e);
      close_out;
   end
endmodule
`default_nettype wire

/* hw/boot_chk.sv */
// Purpose: Error codes, checksums, hex record checks and password check.
// Assumes: Receiver, transmitter and flash reader are on ref_clk.
// Notes:   A halt is left only through rstn.
`timescale 1ns/1ns
`default_nettype none
module boot_chk
   import boot_chk_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // Error events from framing logic
   input  wire logic        ev_baud_err,
   input  wire logic        ev_cmd_err,
   input  wire logic        ev_frame_err,
   input  wire logic        ev_overrun_err,
   // Receive stream
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_err,
   // Mode control
   input  wire logic        dl_start,
   input  wire logic        pwd_start,
   input  wire logic        sum_start,
   input  wire logic [2:0]  sum_mode,
   input  wire logic [15:0] sum_lo,
   input  wire logic [15:0] sum_hi,
   input  wire logic [7:0]  xfer_index,
   input  wire logic [7:0]  xfer_byte,
   input  wire logic        xfer_valid,
   input  wire logic        erase_mode,
   // Flash read port
   output logic [15:0]      fl_addr,
   output logic             fl_rd,
   input  wire logic [7:0]  fl_data,
   input  wire logic        fl_ack,
   // Transmitter
   input  wire logic        tx_ready,
   output logic             tx_valid,
   output logic [7:0]       tx_data,
   // Status
   output logic [15:0]      checksum,
   output logic             sum_done,
   output logic             dl_ok,
   output logic             pwd_ok,
   output logic             blank,
   output logic             halted
);
   // ==========================================================
   // Master state.
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0000, ST_ERR    = 4'b0001, ST_HALT  = 4'b0010,
      ST_WAIT   = 4'b0011, ST_LEN    = 4'b0100, ST_ADDR  = 4'b0101,
      ST_TYPE   = 4'b0110, ST_BODY   = 4'b0111, ST_CSUM  = 4'b1000,
      ST_BLANK  = 4'b1001, ST_PADDR  = 4'b1010, ST_PCNT  = 4'b1011,
      ST_PSTR   = 4'b1100, ST_SCAN   = 4'b1101
   } state_t;

   state_t      state, next_state;
   logic [7:0]  err_code, next_err_code;
   logic        err_req, next_err_req;
   logic [7:0]  len, next_len, rec_type, next_rec_type;
   logic [7:0]  cnt, next_cnt, rsum, next_rsum;
   logic [15:0] addr, next_addr, ext, next_ext;
   logic [15:0] ram_lo, next_ram_lo, ram_hi, next_ram_hi;
   logic        ram_seen, next_ram_seen;
   logic [15:0] cnt_loc, next_cnt_loc, cmp_start, next_cmp_start;
   logic [7:0]  pcount, next_pcount, prev, next_prev;
   logic [1:0]  rep, next_rep;
   logic [15:0] next_fl_addr, scan_end, next_scan_end;
   logic        next_fl_rd, next_dl_ok, next_pwd_ok, next_blank;
   logic        next_halted, next_sum_done, sum_clear, sum_add;
   logic [7:0]  sum_byte;
   logic [7:0]  pwd_byte, next_pwd_byte;
   logic        err_done;
   logic [15:0] acc;

   // A stored comparison byte is fetched before each host byte arrives.
   function automatic logic in_pwd_area(input logic [15:0] a);
      in_pwd_area = (a >= FLASH_LO) && (a <= PWD_HI);
   endfunction

   // ==========================================================
   // Error code sender and checksum accumulator.
   err_sender u_err (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .req      (err_req),
      .code     (err_code),
      .tx_ready (tx_ready),
      .tx_valid (tx_valid),
      .tx_data  (tx_data),
      .done     (err_done)
   );

   sum_acc u_sum (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .clear   (sum_clear),
      .add     (sum_add),
      .data    (sum_byte),
      .sum     (acc)
   );

   // ==========================================================
   // Next-state logic for every part of the block.
   always_comb begin
      next_state = state;      next_err_code = err_code;
      next_err_req = 1'b0;     next_len = len;
      next_rec_type = rec_type; next_cnt = cnt;
      next_rsum = rsum;        next_addr = addr;
      next_ext = ext;          next_ram_lo = ram_lo;
      next_ram_hi = ram_hi;    next_ram_seen = ram_seen;
      next_cnt_loc = cnt_loc;  next_cmp_start = cmp_start;
      next_pcount = pcount;    next_prev = prev;
      next_rep = rep;
      next_fl_addr = fl_addr;  next_fl_rd = 1'b0;
      next_scan_end = scan_end; next_dl_ok = 1'b0;
      next_pwd_ok = 1'b0;      next_blank = blank;
      next_halted = halted;    next_sum_done = 1'b0;
      next_pwd_byte = pwd_byte;
      sum_clear = 1'b0;        sum_add = 1'b0;
      sum_byte = fl_data;
      case (state)
         ST_IDLE: begin
            // Error codes take priority over any mode start.
            if (ev_frame_err) begin
               next_err_code = ERR_FRAME; next_err_req = 1'b1;
               next_state = ST_ERR;
            end else if (ev_overrun_err) begin
               next_err_code = ERR_OVERRUN; next_err_req = 1'b1;
               next_state = ST_ERR;
            end else if (ev_baud_err) begin
               next_err_code = ERR_BAUD; next_err_req = 1'b1;
               next_state = ST_ERR;
            end else if (ev_cmd_err) begin
               next_err_code = ERR_CMD; next_err_req = 1'b1;
               next_state = ST_ERR;
            end else if (pwd_start) begin
               next_fl_addr = BLANK_LO; next_fl_rd = 1'b1;
               next_blank = 1'b1; next_state = ST_BLANK;
            end else if (dl_start) begin
               next_ext = 16'h0000; next_ram_seen = 1'b0;
               next_state = ST_WAIT;
            end else if (sum_start) begin
               sum_clear = 1'b1;
               case (sum_mode)
                  SUM_FLASH: begin
                     next_fl_addr = FLASH_LO; next_scan_end = FLASH_HI;
                  end
                  SUM_RAM: begin
                     next_fl_addr = ram_lo; next_scan_end = ram_hi;
                  end
                  SUM_ERASE: begin
                     next_fl_addr = sum_lo; next_scan_end = sum_hi;
                  end
                  default: begin
                     next_fl_addr = 16'h0000; next_scan_end = 16'h0000;
                  end
               endcase
               next_fl_rd = (sum_mode == SUM_FLASH) ||
                            (sum_mode == SUM_RAM) || (sum_mode == SUM_ERASE);
               next_state = ST_SCAN;
            end
         end
         ST_ERR: begin
            if (err_done) begin
               next_halted = 1'b1; next_state = ST_HALT;
            end
         end
         ST_HALT: begin
            next_halted = 1'b1;
         end
         ST_SCAN: begin
            if (sum_mode == SUM_ID || sum_mode == SUM_STAT) begin
               sum_byte = xfer_byte;
               if (xfer_valid && xfer_index >= ID_FIRST &&
                   ((sum_mode == SUM_ID   && xfer_index <= ID_LAST) ||
                    (sum_mode == SUM_STAT && xfer_index <= ST_LAST)))
               begin
                  sum_add = 1'b1;
               end
               if (xfer_valid && ((sum_mode == SUM_ID && xfer_index == ID_LAST)
                   || (sum_mode == SUM_STAT && xfer_index == ST_LAST))) begin
                  next_sum_done = 1'b1; next_state = ST_IDLE;
               end
            end else if (fl_ack) begin
               sum_add = 1'b1;
               if (fl_addr == scan_end) begin
                  next_sum_done = 1'b1; next_state = ST_IDLE;
               end else begin
                  next_fl_addr = fl_addr + 16'h0001; next_fl_rd = 1'b1;
               end
            end
         end
         ST_BLANK: begin
            if (fl_ack) begin
               if (fl_data != ERASED) next_blank = 1'b0;
               if (fl_addr == FLASH_HI) begin
                  next_cnt = 8'h00; next_state = ST_PADDR;
               end else begin
                  next_fl_addr = fl_addr + 16'h0001; next_fl_rd = 1'b1;
               end
            end
         end
         ST_PADDR: begin
            // Both address fields arrive even for a blank part.
            if (rx_valid && rx_err) begin
               next_halted = 1'b1; next_state = ST_HALT;
            end else if (rx_valid) begin
               case (cnt[1:0])
                  2'h0: next_cnt_loc[15:8]   = rx_data;
                  2'h1: next_cnt_loc[7:0]    = rx_data;
                  2'h2: next_cmp_start[15:8] = rx_data;
                  default: next_cmp_start[7:0] = rx_data;
               endcase
               next_cnt = cnt + 8'h01;
               if (cnt[1:0] == 2'h3) begin
                  if (!in_pwd_area(cnt_loc) ||
                      !in_pwd_area({cmp_start[15:8], rx_data})) begin
                     next_halted = 1'b1; next_state = ST_HALT;
                  end else if (blank) begin
                     // Blank: skip compare; stray bytes are ignored in ST_IDLE.
                     next_pwd_ok = 1'b1; next_state = ST_IDLE;
                  end else begin
                     next_fl_addr = cnt_loc; next_fl_rd = 1'b1;
                     next_state = ST_PCNT;
                  end
               end
            end
         end
         ST_PCNT: begin
            if (fl_ack) begin
               next_pcount = fl_data;
               if (fl_data < PWD_MIN ||
                   {8'h00, fl_data} > PWD_END - cmp_start) begin
                  next_halted = 1'b1; next_state = ST_HALT;
               end else begin
                  next_fl_addr = cmp_start; next_fl_rd = 1'b1;
                  next_cnt = 8'h00; next_rep = 2'h0;
                  next_state = ST_PSTR;
               end
            end
         end
         ST_PSTR: begin
            if (fl_ack) next_pwd_byte = fl_data;
            if (rx_valid) begin
               if (rx_err || rx_data != pwd_byte) begin
                  next_halted = 1'b1; next_state = ST_HALT;
               end else if (cnt != 8'h00 && rx_data == prev && rep != 2'h0)
               begin
                  next_halted = 1'b1; next_state = ST_HALT;
               end else begin
                  next_rep = (cnt != 8'h00 && rx_data == prev) ? 2'h1 : 2'h0;
                  next_prev = rx_data; next_cnt = cnt + 8'h01;
                  if (cnt + 8'h01 == pcount) begin
                     next_pwd_ok = 1'b1; next_state = ST_IDLE;
                  end else begin
                     next_fl_addr = fl_addr + 16'h0001; next_fl_rd = 1'b1;
                  end
               end
            end
         end
         ST_WAIT: begin
            if (rx_valid && rx_data == START_MARK) begin
               next_rsum = 8'h00; next_state = ST_LEN;
            end
         end
         ST_LEN, ST_ADDR, ST_TYPE, ST_BODY, ST_CSUM: begin
            if (rx_valid && rx_err) begin
               next_halted = 1'b1; next_state = ST_HALT;
            end else if (rx_valid) begin
               next_rsum = rsum + rx_data;
               next_cnt = cnt + 8'h01;
               case (state)
                  ST_LEN: begin
                     next_len = rx_data; next_cnt = 8'h00;
                     next_state = ST_ADDR;
                  end
                  ST_ADDR: begin
                     if (cnt == 8'h00) next_addr[15:8] = rx_data;
                     else begin
                        next_addr[7:0] = rx_data; next_state = ST_TYPE;
                     end
                  end
                  ST_TYPE: begin
                     next_rec_type = rx_data; next_cnt = 8'h00;
                     if ((rx_data != REC_DATA && rx_data != REC_END &&
                          rx_data != REC_EXT) ||
                         (rx_data == REC_EXT && len != EXT_LEN) ||
                         (rx_data == REC_END && len != END_LEN) ||
                         (rx_data == REC_DATA && ext >= EXT_LIMIT)) begin
                        next_halted = 1'b1; next_state = ST_HALT;
                     end else begin
                        next_state = (len == 8'h00) ? ST_CSUM : ST_BODY;
                     end
                  end
                  ST_BODY: begin
                     if (rec_type == REC_EXT) begin
                        if (cnt == 8'h00) next_ext[15:8] = rx_data;
                        else next_ext[7:0] = rx_data;
                     end else begin
                        // Track the RAM span for the loader sum.
                        if (!ram_seen || addr < ram_lo) next_ram_lo = addr;
                        if (!ram_seen || addr > ram_hi) next_ram_hi = addr;
                        next_ram_seen = 1'b1;
                        next_addr = addr + 16'h0001;
                     end
                     if (cnt + 8'h01 == len) next_state = ST_CSUM;
                  end
                  default: begin
                     if (rsum + rx_data != 8'h00) begin
                        next_halted = 1'b1; next_state = ST_HALT;
                     end else if (rec_type == REC_END) begin
                        next_dl_ok = 1'b1; next_state = ST_IDLE;
                     end else begin
                        next_state = ST_WAIT;
                     end
                  end
               endcase
            end
         end
         default: next_state = ST_HALT;
      endcase
   end

   // ==========================================================
   // State registers; nothing but a reset leaves the halt.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;    err_code <= 8'h00;  err_req <= 1'b0;
         len <= 8'h00;        rec_type <= 8'h00;  cnt <= 8'h00;
         rsum <= 8'h00;       addr <= 16'h0000;   ext <= 16'h0000;
         ram_lo <= 16'h0000;  ram_hi <= 16'h0000; ram_seen <= 1'b0;
         cnt_loc <= 16'h0000; cmp_start <= 16'h0000;
         pcount <= 8'h00;     prev <= 8'h00;      rep <= 2'h0;
         fl_addr <= 16'h0000; fl_rd <= 1'b0;
         scan_end <= 16'h0000; dl_ok <= 1'b0;     pwd_ok <= 1'b0;
         blank <= 1'b0;       halted <= 1'b0;     sum_done <= 1'b0;
         pwd_byte <= 8'h00;   checksum <= 16'h0000;
      end else begin
         state <= next_state; err_code <= next_err_code;
         err_req <= next_err_req;
         len <= next_len;     rec_type <= next_rec_type; cnt <= next_cnt;
         rsum <= next_rsum;   addr <= next_addr;  ext <= next_ext;
         ram_lo <= next_ram_lo; ram_hi <= next_ram_hi;
         ram_seen <= next_ram_seen;
         cnt_loc <= next_cnt_loc; cmp_start <= next_cmp_start;
         pcount <= next_pcount; prev <= next_prev; rep <= next_rep;
         fl_addr <= next_fl_addr; fl_rd <= next_fl_rd;
         scan_end <= next_scan_end; dl_ok <= next_dl_ok;
         pwd_ok <= next_pwd_ok; blank <= next_blank;
         halted <= next_halted; sum_done <= next_sum_done;
         pwd_byte <= next_pwd_byte;
         checksum <= acc;
      end
   end
endmodule
`default_nettype wire

/* hw/boot_chk_pkg.sv */
// Purpose: Shared constants for the serial boot checker block.
// Assumes: Byte-wide receive stream, 16-bit flash addressing.
// Notes:   Every code, address and bound lives here by name.
package boot_chk_pkg;
   // ==========================================================
   // Error codes sent three times before the halt.
   localparam logic [7:0] ERR_BAUD    = 8'h62;
   localparam logic [7:0] ERR_CMD     = 8'h63;
   localparam logic [7:0] ERR_FRAME   = 8'ha1;
   localparam logic [7:0] ERR_OVERRUN = 8'ha3;
   localparam logic [1:0] ERR_REPEAT  = 2'h3;
   // ==========================================================
   // Hex record fields.
   localparam logic [7:0] START_MARK  = 8'h3a;
   localparam logic [7:0] REC_DATA    = 8'h00;
   localparam logic [7:0] REC_END     = 8'h01;
   localparam logic [7:0] REC_EXT     = 8'h02;
   localparam logic [7:0] EXT_LEN     = 8'h02;
   localparam logic [7:0] END_LEN     = 8'h00;
   localparam logic [15:0] EXT_LIMIT  = 16'h1000;
   // ==========================================================
   // Flash map and password bounds.
   localparam logic [15:0] FLASH_LO   = 16'hc000;
   localparam logic [15:0] FLASH_HI   = 16'hffff;
   localparam logic [15:0] PWD_HI     = 16'hff9f;
   localparam logic [15:0] PWD_END    = 16'hffa0;
   localparam logic [15:0] BLANK_LO   = 16'hffe0;
   localparam logic [7:0]  ERASED     = 8'hff;
   localparam logic [7:0]  PWD_MIN    = 8'h08;
   // Transfer byte windows for the identification and status sums.
   localparam logic [7:0]  ID_FIRST   = 8'h09;
   localparam logic [7:0]  ID_LAST    = 8'h12;
   localparam logic [7:0]  ST_FIRST   = 8'h09;
   localparam logic [7:0]  ST_LAST    = 8'h0c;
   // ==========================================================
   // Checksum coverage modes.
   typedef enum logic [2:0] {
      SUM_FLASH = 3'b000,
      SUM_RAM   = 3'b001,
      SUM_ID    = 3'b010,
      SUM_STAT  = 3'b011,
      SUM_ERASE = 3'b100
   } sum_mode_t;
endpackage

/* hw/err_sender.sv */
// Purpose: Sends one error code three times, then asks for the halt.
// Assumes: Transmitter accepts a byte when tx_ready is high.
// Notes:   Busy from request until the third byte is taken.
`timescale 1ns/1ns
`default_nettype none
module err_sender
   import boot_chk_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   // Request
   input  wire logic       req,
   input  wire logic [7:0] code,
   // Transmitter
   input  wire logic       tx_ready,
   output logic            tx_valid,
   output logic [7:0]      tx_data,
   output logic            done
);
   logic [1:0] sent;
   logic [1:0] next_sent;
   logic       next_tx_valid;
   logic [7:0] next_tx_data;
   logic       next_done;

   // ==========================================================
   // Count the copies; the code is latched so a later change is ignored.
   always_comb begin
      next_sent     = sent;
      next_tx_valid = tx_valid;
      next_tx_data  = tx_data;
      next_done     = 1'b0;
      if (!tx_valid && req) begin
         next_tx_valid = 1'b1;
         next_tx_data  = code;
         next_sent     = 2'h0;
      end else if (tx_valid && tx_ready) begin
         if (sent == ERR_REPEAT - 2'h1) begin
            next_tx_valid = 1'b0;
            next_done     = 1'b1;
         end
         next_sent = sent + 2'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sent     <= 2'h0;
         tx_valid <= 1'b0;
         tx_data  <= 8'h00;
         done     <= 1'b0;
      end else begin
         sent     <= next_sent;
         tx_valid <= next_tx_valid;
         tx_data  <= next_tx_data;
         done     <= next_done;
      end
   end
endmodule
`default_nettype wire

/* hw/sum_acc.sv */
// Purpose: Sixteen-bit byte-wise checksum accumulator.
// Assumes: One byte per add strobe.
// Notes:   Carries beyond bit 15 are dropped on purpose.
`timescale 1ns/1ns
`default_nettype none
module sum_acc (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // Control
   input  wire logic        clear,
   input  wire logic        add,
   input  wire logic [7:0]  data,
   // Result
   output logic [15:0]      sum
);
   logic [15:0] next_sum;

   // ==========================================================
   // Clear wins so a new mode starts from zero.
   always_comb begin
      next_sum = sum;
      if (clear) begin
         next_sum = 16'h0000;
      end else if (add) begin
         next_sum = sum + {8'h00, data};
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sum <= 16'h0000;
      end else begin
         sum <= next_sum;
      end
   end
endmodule
`default_nettype wire
